// ### verilog/ubt_pkg.sv
package ubt_pkg;
  // Status bit positions
  localparam int TOGGLE_BIT = 0;
  localparam int BANK_BIT   = 2;
  // Reset values
  localparam logic RST_TOGGLE = 1'b0;
  localparam logic RST_BANK   = 1'b0;
  // Token types
  typedef enum logic [1:0] {
    UBT_TOK_OUT   = 2'h0,
    UBT_TOK_IN    = 2'h1,
    UBT_TOK_SETUP = 2'h2
  } ubt_token_t;
  // Status width
  localparam int STATUS_W = 8;
endpackage : ubt_pkg

// ### verilog/ubt_bank_sel.sv
`timescale 1ns/100ps
// Current bank tracker for one endpoint
module ubt_bank_sel (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Control
  input  wire logic dual_bank_in,
  input  wire logic pkt_done_in,
  // Status
  output logic      current_bank_select_out
);
  logic bank_q;

  // Flip bank after each packet when both banks in use
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      bank_q <= ubt_pkg::RST_BANK;
    end else if (pkt_done_in && dual_bank_in) begin
      bank_q <= ~bank_q;
    end
  end

  assign current_bank_select_out = bank_q;

  AST_BANK_FLIP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (pkt_done_in && dual_bank_in) |=> (bank_q != $past(bank_q)))
    else $error("bank did not flip after packet");
  AST_BANK_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !(pkt_done_in && dual_bank_in) |=> $stable(bank_q))
    else $error("bank changed without packet");
  COV_BANK_FLIP: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    pkt_done_in && dual_bank_in ##1 pkt_done_in && dual_bank_in);
endmodule : ubt_bank_sel

// ### verilog/ubt_ep_status.sv
`timescale 1ns/100ps
// What this block does
// - A current bank bit picks bank 0 or bank 1 for the next packet on the endpoint.
// - A one written to the toggle position of the status clear register clears the toggle.
// - A one written to the toggle position of the status set register sets the toggle.
// - Hardware inverts the toggle when each data transaction completes.
// - One toggle serves all token types: a SETUP forces DATA1 next, IN and OUT toggle.
// - Toggle 0 means the next transaction uses DATA0, toggle 1 means DATA1.
module ubt_ep_status (
  // Clock and reset
  input  wire logic                          clk_in,
  input  wire logic                          rst_n_in,
  // Software strobes
  input  wire logic                          status_clr_wr_in,
  input  wire logic [ubt_pkg::STATUS_W-1:0]  endpoint_status_clear_reg_in,
  input  wire logic                          status_set_wr_in,
  input  wire logic [ubt_pkg::STATUS_W-1:0]  endpoint_status_set_reg_in,
  // Link events
  input  wire logic                          dual_bank_in,
  input  wire logic                          xact_done_in,
  input  wire ubt_pkg::ubt_token_t           xact_token_in,
  // Status outputs
  output logic [ubt_pkg::STATUS_W-1:0]       status_out,
  output logic                               data_toggle_state_out,
  output logic                               expect_data1_out,
  output logic                               current_bank_select_out
);
  logic toggle_q;
  logic toggle_d;
  logic bank_w;
  logic clr_hit;
  logic set_hit;
  logic data_done;
  logic setup_done;
  logic skip_done;
  logic any_cause;
  logic bank_cause;

  // True for tokens whose data phase inverts the toggle
  function automatic logic is_data_token(input ubt_pkg::ubt_token_t tok);
    is_data_token = (tok == ubt_pkg::UBT_TOK_IN) || (tok == ubt_pkg::UBT_TOK_OUT);
  endfunction : is_data_token

  // Decode write-one strobes
  assign clr_hit = status_clr_wr_in && endpoint_status_clear_reg_in[ubt_pkg::TOGGLE_BIT];
  assign set_hit = status_set_wr_in && endpoint_status_set_reg_in[ubt_pkg::TOGGLE_BIT];

  // Completion classes, used by the checks below
  assign data_done  = xact_done_in && is_data_token(xact_token_in);
  assign setup_done = xact_done_in && (xact_token_in == ubt_pkg::UBT_TOK_SETUP);
  assign skip_done  = xact_done_in && !data_done && !setup_done;
  assign any_cause  = clr_hit || set_hit || xact_done_in;
  assign bank_cause = xact_done_in && dual_bank_in;

  // Next toggle: hardware event wins over software
  always_comb begin
    toggle_d = toggle_q;
    if (clr_hit) begin
      toggle_d = 1'b0;
    end
    if (set_hit) begin
      toggle_d = 1'b1;
    end
    if (xact_done_in) begin
      case (xact_token_in)
        ubt_pkg::UBT_TOK_SETUP: toggle_d = 1'b1;
        ubt_pkg::UBT_TOK_IN,
        ubt_pkg::UBT_TOK_OUT:   toggle_d = ~toggle_q;
        default:                toggle_d = toggle_q;
      endcase
    end
  end

  // Toggle register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      toggle_q <= ubt_pkg::RST_TOGGLE;
    end else begin
      toggle_q <= toggle_d;
    end
  end

  // Bank tracker
  ubt_bank_sel u_bank (
    .clk_in                  (clk_in),
    .rst_n_in                (rst_n_in),
    .dual_bank_in            (dual_bank_in),
    .pkt_done_in             (xact_done_in),
    .current_bank_select_out (bank_w)
  );

  // Status word
  always_comb begin
    status_out = '0;
    status_out[ubt_pkg::TOGGLE_BIT] = toggle_q;
    status_out[ubt_pkg::BANK_BIT]   = bank_w;
  end
  assign data_toggle_state_out   = toggle_q;
  assign expect_data1_out        = toggle_q;
  assign current_bank_select_out = bank_w;

  // Checks on the toggle and the bank bit

  // Clear alone drops the toggle
  AST_CLR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (clr_hit && !set_hit && !xact_done_in) |=> !toggle_q)
    else $error("toggle not cleared");

  // Set without completion raises the toggle
  AST_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (set_hit && !xact_done_in) |=> toggle_q)
    else $error("toggle not set");

  // IN or OUT completion inverts the toggle
  AST_FLIP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    data_done |=> toggle_q != $past(toggle_q))
    else $error("toggle not inverted");

  // SETUP completion leaves DATA1 next
  AST_SETUP: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    setup_done |=> toggle_q)
    else $error("setup did not leave DATA1 next");

  // No cause, no change
  AST_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !any_cause |=> $stable(toggle_q))
    else $error("toggle changed without cause");

  // PID select follows the status bit
  AST_PID: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    expect_data1_out == status_out[ubt_pkg::TOGGLE_BIT])
    else $error("pid select mismatch");

  // Bank swaps after each packet in dual mode
  AST_BANK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    bank_cause |=> current_bank_select_out != $past(current_bank_select_out))
    else $error("bank bit not swapped");

  // Bank bit sits at its status position
  AST_BANKPOS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    status_out[ubt_pkg::BANK_BIT] == current_bank_select_out)
    else $error("bank status bit mismatch");

  // Data completion beats software in the same cycle
  AST_XACT_WINS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (data_done && (set_hit || clr_hit)) |=> toggle_q != $past(toggle_q))
    else $error("software write beat completion");

  // SETUP completion beats a clear
  AST_SETUP_WINS: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (setup_done && clr_hit) |=> toggle_q)
    else $error("clear beat setup completion");

  // SETUP completion with a set still leaves DATA1
  AST_SETUP_SET: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (setup_done && set_hit) |=> toggle_q)
    else $error("setup with set lost DATA1");

  // Unused token code leaves the toggle alone
  AST_SKIP_HOLD: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (skip_done && !set_hit && !clr_hit) |=> $stable(toggle_q))
    else $error("unused token moved toggle");

  // Set beats clear in the same cycle
  AST_SET_OVER_CLR: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (set_hit && clr_hit && !xact_done_in) |=> toggle_q)
    else $error("clear beat set");

  // Clear write with toggle bit zero is ignored
  AST_CLR_IGNORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status_clr_wr_in && !clr_hit && !set_hit && !xact_done_in) |=> $stable(toggle_q))
    else $error("clear write without toggle bit acted");

  // Set write with toggle bit zero is ignored
  AST_SET_IGNORE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status_set_wr_in && !set_hit && !clr_hit && !xact_done_in) |=> $stable(toggle_q))
    else $error("set write without toggle bit acted");

  // Every toggle change has a cause one cycle before
  AST_TOGGLE_CAUSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !$stable(toggle_q) |-> $past(any_cause))
    else $error("toggle changed with no cause");

  // Every bank change follows a dual-bank packet
  AST_BANK_CAUSE: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !$stable(current_bank_select_out) |-> $past(bank_cause))
    else $error("bank changed with no packet");

  // Single-bank endpoint keeps its bank
  AST_SINGLE_BANK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !dual_bank_in |=> $stable(current_bank_select_out))
    else $error("single bank endpoint swapped bank");

  // SETUP packet also swaps the bank in dual mode
  AST_SETUP_BANK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (setup_done && dual_bank_in) |=> current_bank_select_out != $past(current_bank_select_out))
    else $error("setup packet kept bank");

  // Unused token packet also swaps the bank in dual mode
  AST_SKIP_BANK: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (skip_done && dual_bank_in) |=> current_bank_select_out != $past(current_bank_select_out))
    else $error("unused token packet kept bank");

  // Unused status bit 1, between toggle and bank, reads as zero
  AST_RSV_ZERO: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    (status_out[ubt_pkg::BANK_BIT-1:ubt_pkg::TOGGLE_BIT+1] == '0))
    else $error("reserved status bit set");

  // Toggle output matches the status bit
  AST_TOGGLE_OUT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    data_toggle_state_out == status_out[ubt_pkg::TOGGLE_BIT])
    else $error("toggle output mismatch");

  // Toggle zero means DATA0 next
  AST_DATA0_NEXT: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !toggle_q |-> !expect_data1_out)
    else $error("DATA1 flagged with toggle zero");

  // Main scenarios
  COV_CLR: cover property (@(posedge clk_in) disable iff (!rst_n_in) clr_hit ##1 !toggle_q);
  COV_SET: cover property (@(posedge clk_in) disable iff (!rst_n_in) set_hit ##1 toggle_q);
  COV_SETUP: cover property (@(posedge clk_in) disable iff (!rst_n_in)
    xact_done_in && xact_token_in == ubt_pkg::UBT_TOK_SETUP);
  COV_TWO: cover property (@(posedge clk_in) disable iff (!rst_n_in) xact_done_in ##1 xact_done_in);
endmodule : ubt_ep_status

// ### verification/ubt_usb_partner.sv
`timescale 1ns/100ps
// Bus side that reports finished data transactions
module ubt_usb_partner (
  // Clock and request from the bench
  input  wire logic                clk_in,
  input  wire logic                req_in,
  input  wire ubt_pkg::ubt_token_t tok_in,
  // Completion towards the endpoint logic
  output logic                     done_out,
  output ubt_pkg::ubt_token_t      token_out
);
  // Idle before the first edge
  initial done_out = 1'b0;
  initial token_out = ubt_pkg::ubt_token_t'(2'h3);
  // One-cycle completion pulse, idle token when quiet
  always @(posedge clk_in) begin
    done_out  <= req_in;
    token_out <= req_in ? tok_in : ubt_pkg::ubt_token_t'(2'h3);
  end
endmodule : ubt_usb_partner

// ### verification/test_usb_endpoint_bank_toggle_status.sv
`timescale 1ns/100ps
module test_usb_endpoint_bank_toggle_status;
  logic clk_in = 1'b0, rst_n_in = 1'b0, sw_s = 1'b0, sw_c = 1'b0, dual = 1'b0, req = 1'b0, done, t1, d1, bk;
  logic [7:0] sw_d = 8'h00, st;
  logic et = 1'b0, eb = 1'b0;
  int fails = 0, samples_checked = 0;
  ubt_pkg::ubt_token_t tok = ubt_pkg::UBT_TOK_OUT, tok_q;
  // Clock at 100 ns
  always #50 clk_in = ~clk_in;
  ubt_usb_partner PTN (.clk_in(clk_in), .req_in(req), .tok_in(tok), .done_out(done), .token_out(tok_q));
  ubt_ep_status DUT (.clk_in(clk_in), .rst_n_in(rst_n_in), .status_clr_wr_in(sw_c),
    .endpoint_status_clear_reg_in(sw_d), .status_set_wr_in(sw_s), .endpoint_status_set_reg_in(sw_d),
    .dual_bank_in(dual), .xact_done_in(done), .xact_token_in(tok_q), .status_out(st),
    .data_toggle_state_out(t1), .expect_data1_out(d1), .current_bank_select_out(bk));
  // Compare and count
  task automatic check(input logic [10:0] seen, input logic [10:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("[ERR] %0t seen=%h want=%h", $time, seen, want);
    end
  endtask : check
  task automatic look;
    check({st, t1, d1, bk}, {5'h00, eb, 1'b0, et, et, et, eb});
  endtask : look
  // Software write, one-cycle strobe
  task automatic sw(input logic s, input logic c, input logic [7:0] d);
    @(negedge clk_in) {sw_s, sw_c, sw_d} = {s, c, d};
    @(negedge clk_in) {sw_s, sw_c} = 2'h0;
  endtask : sw
  // One transaction through the partner
  task automatic xact(input ubt_pkg::ubt_token_t t);
    @(negedge clk_in) {req, tok} = {1'b1, t};
    @(negedge clk_in) req = 1'b0;
    @(negedge clk_in);
  endtask : xact
  task automatic sc_soft;
    sw(1'b1, 1'b0, 8'hFE); look();
    sw(1'b1, 1'b0, 8'h01); et = 1'b1; look();
    sw(1'b0, 1'b1, 8'hFE); look();
    sw(1'b1, 1'b1, 8'h01); look();
    sw(1'b0, 1'b1, 8'hFF); et = 1'b0; look();
  endtask : sc_soft
  task automatic sc_xact;
    xact(ubt_pkg::UBT_TOK_IN); et = ~et; look();
    xact(ubt_pkg::UBT_TOK_OUT); et = ~et; look();
    xact(ubt_pkg::UBT_TOK_SETUP); et = 1'b1; look();
    xact(ubt_pkg::ubt_token_t'(2'h3)); look();
    dual = 1'b1;
    xact(ubt_pkg::UBT_TOK_IN); et = ~et; eb = ~eb; look();
    xact(ubt_pkg::UBT_TOK_OUT); et = ~et; eb = ~eb; look();
  endtask : sc_xact
  task automatic end_sim;
    if (fails == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // Run guard
  initial begin
    repeat (5000) @(posedge clk_in);
    fails++;
    end_sim();
  end
  initial begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    look();
    sc_soft();
    sc_xact();
    end_sim();
  end
endmodule : test_usb_endpoint_bank_toggle_status
